// file: cioflx_exec.sv
module cioflx_exec (
  input  wire logic                    MCLK_I,
  input  wire logic                    RESETN_I,
  input  wire cioflx_pkg::cioflx_variant_t VARIANT_I,
  input  wire cioflx_pkg::cioflx_cmd_t CMD_I,
  input  wire cioflx_pkg::cioflx_stack_t STACK_I,
  input  wire logic                    CONTACT_IN_1_I,
  output logic                         STACK_WE_O,
  output cioflx_pkg::cioflx_stack_t    STACK_O,
  output logic                         CMD_ERR_O,
  output logic                         PASS_END_O,
  output logic                         CONTACT_OUT_1_O,
  output logic                         CONTACT_OUT_2_O
);
  import cioflx_pkg::*;

  logic [2:0] in_sync;
  logic       contact_in_1;
  logic       contact_out_reg_1;
  logic       contact_out_reg_2;
  logic [4:1] user_flag;
  logic       legal;
  logic       push;
  logic       push_bit;
  logic       store_bit;
  logic       next_contact_in_1;

  // Pin sampled through three stages; a change counts when stages 2 and 3 agree
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      in_sync <= {3{STATE_RELEASED}};
    end else begin
      in_sync <= {in_sync[1:0], CONTACT_IN_1_I};
    end
  end

  always_comb begin
    next_contact_in_1 = contact_in_1;
    if (in_sync[1] == in_sync[2]) begin
      next_contact_in_1 = in_sync[2];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      contact_in_1 <= STATE_RELEASED;
    end else begin
      contact_in_1 <= next_contact_in_1;
    end
  end

  // Below 0.5 is energized; signed, so a negative top also energizes
  assign store_bit = ($signed(STACK_I.s1) < $signed(VAL_HALF)) ?
                     STATE_ENERGIZED : STATE_RELEASED;

  always_comb begin
    legal = 1'b0;
    case (CMD_I.op)
      CIOFLX_OP_NOP, CIOFLX_OP_SWAP, CIOFLX_OP_TERMINATE: legal = 1'b1;
      CIOFLX_OP_LOAD_IN_1: legal = (VARIANT_I == CIOFLX_VAR_STD);
      CIOFLX_OP_LOAD_OUT_1, CIOFLX_OP_DRIVE_OUT_1:
        legal = (VARIANT_I != CIOFLX_VAR_NONE);
      CIOFLX_OP_LOAD_OUT_2, CIOFLX_OP_DRIVE_OUT_2:
        legal = (VARIANT_I == CIOFLX_VAR_OPT);
      CIOFLX_OP_LOAD_FLAG, CIOFLX_OP_STORE_FLAG: begin
        case (VARIANT_I)
          CIOFLX_VAR_STD:  legal = (CMD_I.index >= 3'd2) &&
                                   (CMD_I.index <= 3'd4);
          CIOFLX_VAR_OPT:  legal = (CMD_I.index >= 3'd3) &&
                                   (CMD_I.index <= 3'd4);
          CIOFLX_VAR_NONE: legal = (CMD_I.index >= 3'd1) &&
                                   (CMD_I.index <= 3'd4);
          default:         legal = 1'b0;
        endcase
      end
      default: legal = 1'b0;
    endcase
  end

  // Flag 1, and flag 2 in the no-contact variant only, share storage with the
  // output registers, so a no-contact variant reads them back as plain flags
  always_comb begin
    push     = 1'b0;
    push_bit = STATE_ENERGIZED;
    case (CMD_I.op)
      CIOFLX_OP_LOAD_IN_1: begin
        push     = 1'b1;
        push_bit = contact_in_1;
      end
      CIOFLX_OP_LOAD_OUT_1: begin
        push     = 1'b1;
        push_bit = contact_out_reg_1;
      end
      CIOFLX_OP_LOAD_OUT_2: begin
        push     = 1'b1;
        push_bit = contact_out_reg_2;
      end
      CIOFLX_OP_LOAD_FLAG: begin
        push = 1'b1;
        case (CMD_I.index)
          3'd1:    push_bit = contact_out_reg_1;
          3'd2:    push_bit = (VARIANT_I == CIOFLX_VAR_NONE) ?
                              contact_out_reg_2 : user_flag[2];
          3'd3:    push_bit = user_flag[3];
          3'd4:    push_bit = user_flag[4];
          default: push_bit = STATE_ENERGIZED;
        endcase
      end
      default: begin
        push     = 1'b0;
        push_bit = STATE_ENERGIZED;
      end
    endcase
  end

  // Stack answer is combinational; the sequencer writes it back on STACK_WE_O
  always_comb begin
    STACK_WE_O = 1'b0;
    STACK_O    = STACK_I;
    if (CMD_I.valid && legal && push) begin
      STACK_WE_O = 1'b1;
      STACK_O.s1 = push_bit ? VAL_ONE : VAL_ZERO;
      STACK_O.s2 = STACK_I.s1;
      STACK_O.s3 = STACK_I.s2;
      STACK_O.s4 = STACK_I.s3;
    end else if (CMD_I.valid && CMD_I.op == CIOFLX_OP_SWAP) begin
      STACK_WE_O = 1'b1;
      STACK_O.s1 = STACK_I.s2;
      STACK_O.s2 = STACK_I.s1;
    end
  end

  assign CMD_ERR_O  = CMD_I.valid && !legal;
  assign PASS_END_O = CMD_I.valid && (CMD_I.op == CIOFLX_OP_TERMINATE);

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      contact_out_reg_1 <= OUT_RESET[0];
      contact_out_reg_2 <= OUT_RESET[1];
    end else if (CMD_I.valid && legal) begin
      if (CMD_I.op == CIOFLX_OP_DRIVE_OUT_1 ||
          (CMD_I.op == CIOFLX_OP_STORE_FLAG && CMD_I.index == 3'd1)) begin
        contact_out_reg_1 <= store_bit;
      end
      if (CMD_I.op == CIOFLX_OP_DRIVE_OUT_2 ||
          (CMD_I.op == CIOFLX_OP_STORE_FLAG && CMD_I.index == 3'd2 &&
           VARIANT_I == CIOFLX_VAR_NONE)) begin
        contact_out_reg_2 <= store_bit;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      user_flag <= FLAGS_RESET;
    end else if (CMD_I.valid && legal &&
                 CMD_I.op == CIOFLX_OP_STORE_FLAG &&
                 CMD_I.index >= 3'd2 && CMD_I.index <= 3'd4) begin
      user_flag[CMD_I.index] <= store_bit;
    end
  end

  // Pins idle released when the variant has no such contact
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      CONTACT_OUT_1_O <= STATE_RELEASED;
      CONTACT_OUT_2_O <= STATE_RELEASED;
    end else begin
      CONTACT_OUT_1_O <= (VARIANT_I == CIOFLX_VAR_NONE) ?
                         STATE_RELEASED : contact_out_reg_1;
      CONTACT_OUT_2_O <= (VARIANT_I == CIOFLX_VAR_OPT) ?
                         contact_out_reg_2 : STATE_RELEASED;
    end
  end

  property p_load_value;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      STACK_WE_O && push && legal |->
        (STACK_O.s1 == VAL_ONE || STACK_O.s1 == VAL_ZERO);
  endproperty
  a_load_value: assert property (p_load_value)
    else $error("load value not 0 or 1");

  property p_push;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      STACK_WE_O && push && legal |->
        STACK_O.s2 == STACK_I.s1 && STACK_O.s4 == STACK_I.s3;
  endproperty
  a_push: assert property (p_push)
    else $error("stack push wrong");

  property p_swap;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      CMD_I.valid && CMD_I.op == CIOFLX_OP_SWAP |->
        STACK_O.s1 == STACK_I.s2 && STACK_O.s2 == STACK_I.s1 &&
        STACK_O.s3 == STACK_I.s3 && STACK_O.s4 == STACK_I.s4;
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap wrong");

  property p_store_keeps;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      CMD_I.valid && (CMD_I.op == CIOFLX_OP_STORE_FLAG ||
                      CMD_I.op == CIOFLX_OP_DRIVE_OUT_1) |-> !STACK_WE_O;
  endproperty
  a_store_keeps: assert property (p_store_keeps)
    else $error("store altered stack");

  sequence s_drive1;
    CMD_I.valid && legal && CMD_I.op == CIOFLX_OP_DRIVE_OUT_1;
  endsequence
  property p_threshold;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      s_drive1 ##0 ($signed(STACK_I.s1) < $signed(VAL_HALF)) |=>
        contact_out_reg_1 == STATE_ENERGIZED;
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("threshold wrong");

  property p_readback;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      s_drive1 ##1 (CMD_I.valid && CMD_I.op == CIOFLX_OP_LOAD_OUT_1) |->
        STACK_O.s1 == ($past(store_bit) ? VAL_ONE : VAL_ZERO);
  endproperty
  a_readback: assert property (p_readback)
    else $error("output readback wrong");

  property p_no_in_opt;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      CMD_I.valid && CMD_I.op == CIOFLX_OP_LOAD_IN_1 &&
      VARIANT_I != CIOFLX_VAR_STD |-> CMD_ERR_O && !STACK_WE_O;
  endproperty
  a_no_in_opt: assert property (p_no_in_opt)
    else $error("input load accepted");

  property p_flag_range;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      CMD_I.valid && CMD_I.op == CIOFLX_OP_STORE_FLAG &&
      VARIANT_I == CIOFLX_VAR_OPT && CMD_I.index < 3'd3 |-> CMD_ERR_O;
  endproperty
  a_flag_range: assert property (p_flag_range)
    else $error("flag index accepted");

  property p_terminate;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      CMD_I.valid && CMD_I.op == CIOFLX_OP_TERMINATE |-> PASS_END_O;
  endproperty
  a_terminate: assert property (p_terminate)
    else $error("terminate missed");

  property p_pin_off;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      VARIANT_I == CIOFLX_VAR_NONE ##1 VARIANT_I == CIOFLX_VAR_NONE |->
        CONTACT_OUT_1_O == STATE_RELEASED;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("flag drove pin");

  // A refused command must leave every state bit alone
  property p_refused;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      CMD_ERR_O |-> (!STACK_WE_O && !PASS_END_O) ##1
        ($stable(contact_out_reg_1) && $stable(contact_out_reg_2) &&
         $stable(user_flag));
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused command changed state");

  sequence s_flag_store;
    CMD_I.valid && legal && CMD_I.op == CIOFLX_OP_STORE_FLAG;
  endsequence
  property p_flag_readback;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      s_flag_store ##1 (CMD_I.valid && legal &&
                        CMD_I.op == CIOFLX_OP_LOAD_FLAG &&
                        CMD_I.index == $past(CMD_I.index)) |->
        STACK_O.s1 == ($past(store_bit) ? VAL_ONE : VAL_ZERO);
  endproperty
  a_flag_readback: assert property (p_flag_readback)
    else $error("flag readback wrong");

  property p_out2_std;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      VARIANT_I == CIOFLX_VAR_STD ##1 VARIANT_I == CIOFLX_VAR_STD |->
        CONTACT_OUT_2_O == STATE_RELEASED;
  endproperty
  a_out2_std: assert property (p_out2_std)
    else $error("standard variant drove pin 2");

  // Pin lags the state register by one edge
  property p_out1_follow;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      VARIANT_I != CIOFLX_VAR_NONE ##1 VARIANT_I != CIOFLX_VAR_NONE |->
        CONTACT_OUT_1_O == $past(contact_out_reg_1);
  endproperty
  a_out1_follow: assert property (p_out1_follow)
    else $error("pin 1 does not follow its register");

  property p_terminate_keeps;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      PASS_END_O |-> !STACK_WE_O && !CMD_ERR_O;
  endproperty
  a_terminate_keeps: assert property (p_terminate_keeps)
    else $error("terminate touched the stack");

  sequence s_drive2;
    CMD_I.valid && legal && CMD_I.op == CIOFLX_OP_DRIVE_OUT_2;
  endsequence
  property p_threshold_2;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      s_drive2 ##0 ($signed(STACK_I.s1) >= $signed(VAL_HALF)) |=>
        contact_out_reg_2 == STATE_RELEASED;
  endproperty
  a_threshold_2: assert property (p_threshold_2)
    else $error("threshold on output 2 wrong");
endmodule

// file: cioflx_pkg.sv
package cioflx_pkg;
  localparam int DATA_W = 32;
  localparam int FRAC_W = 16;
  // Fixed point: FRAC_W fraction bits, 1.000 is 1 << FRAC_W
  localparam logic [DATA_W-1:0] VAL_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] VAL_ONE  = 32'h0001_0000;
  localparam logic [DATA_W-1:0] VAL_HALF = 32'h0000_8000;
  localparam logic STATE_ENERGIZED = 1'b0;
  localparam logic STATE_RELEASED  = 1'b1;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [1:0] OUT_RESET   = 2'h3;

  typedef enum logic [1:0] {
    CIOFLX_VAR_STD,
    CIOFLX_VAR_OPT,
    CIOFLX_VAR_NONE
  } cioflx_variant_t;

  typedef enum logic [3:0] {
    CIOFLX_OP_NOP,
    CIOFLX_OP_LOAD_IN_1,
    CIOFLX_OP_LOAD_OUT_1,
    CIOFLX_OP_LOAD_OUT_2,
    CIOFLX_OP_DRIVE_OUT_1,
    CIOFLX_OP_DRIVE_OUT_2,
    CIOFLX_OP_LOAD_FLAG,
    CIOFLX_OP_STORE_FLAG,
    CIOFLX_OP_SWAP,
    CIOFLX_OP_TERMINATE
  } cioflx_op_t;

  typedef struct packed {
    logic             valid;
    cioflx_op_t       op;
    logic [2:0]       index;
  } cioflx_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic [DATA_W-1:0] s4;
  } cioflx_stack_t;
endpackage

// file: cioflx_relay_model.sv
module cioflx_relay_model (
  input  wire logic       out_1_i,
  input  wire logic       out_2_i,
  output logic            contact_in_o,
  output logic [1:0]      closed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released contact reads 1, an energized one 0
  initial contact_in_o = 1'b1;
  assign closed_o = ~{out_2_i, out_1_i};
  // Only the bench moves the input contact, so a change is never mid-edge
  task automatic set_in(input logic v);
    contact_in_o = v;
  endtask
endmodule

// file: cioflx_exec_tb.sv
module cioflx_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cioflx_pkg::*;
  localparam logic [DATA_W-1:0] VAL_A = 32'h0002_1000;
  logic            mclk, resetn, contact_in, we, err, pend, out1, out2;
  logic [1:0]      closed;
  cioflx_variant_t variant;
  cioflx_cmd_t     cmd;
  cioflx_stack_t   stk, so;
  int              err_total, n_checks;

  cioflx_exec dut (.MCLK_I(mclk), .RESETN_I(resetn), .VARIANT_I(variant),
    .CMD_I(cmd), .STACK_I(stk), .CONTACT_IN_1_I(contact_in), .STACK_WE_O(we),
    .STACK_O(so), .CMD_ERR_O(err), .PASS_END_O(pend),
    .CONTACT_OUT_1_O(out1), .CONTACT_OUT_2_O(out2));
  cioflx_relay_model relay (.out_1_i(out1), .out_2_i(out2),
    .contact_in_o(contact_in), .closed_o(closed));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk_val(input logic [DATA_W-1:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    chk_val({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic chk_push(input logic [DATA_W-1:0] top);
    chk_bit(we, 1'b1, "push we");
    chk_val(so.s1, top, "push s1");
    chk_val(so.s2, stk.s1, "push s2");
    chk_val(so.s3, stk.s2, "push s3");
    chk_val(so.s4, stk.s3, "push s4");
  endtask
  task automatic chk_keep();
    chk_bit(we, 1'b0, "keep we");
    chk_val(so.s1, stk.s1, "keep s1");
    chk_val(so.s2, stk.s2, "keep s2");
    chk_val(so.s3, stk.s3, "keep s3");
    chk_val(so.s4, stk.s4, "keep s4");
  endtask
  task automatic run(input cioflx_op_t op, input logic [2:0] idx,
                     input logic [DATA_W-1:0] top);
    @(posedge mclk);
    #1;
    cmd = '{1'b1, op, idx};
    stk.s1 = top;
    #2;
  endtask
  task automatic idle();
    @(posedge mclk);
    #1;
    cmd.valid = 1'b0;
  endtask
  // Pins follow one edge after the state register
  task automatic drive(input cioflx_op_t op, input logic [DATA_W-1:0] top);
    run(op, 3'h0, top);
    chk_keep();
    idle();
    @(posedge mclk);
    #1;
  endtask
  task automatic do_reset(input cioflx_variant_t v);
    @(posedge mclk);
    #1;
    resetn = 1'b0;
    variant = v;
    cmd.valid = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    resetn = 1'b1;
  endtask
  function automatic logic legal(input cioflx_variant_t v, input int i);
    if (v == CIOFLX_VAR_STD) return i >= 2 && i <= 4;
    if (v == CIOFLX_VAR_OPT) return i >= 3 && i <= 4;
    return i >= 1 && i <= 4;
  endfunction

  task automatic t_contact_in();
    do_reset(CIOFLX_VAR_STD);
    chk_bit(out2, 1'b1, "std out2 released");
    for (int v = 0; v < 2; v++) begin
      relay.set_in(v[0]);
      repeat (4) @(posedge mclk);
      run(CIOFLX_OP_LOAD_IN_1, 3'h0, VAL_A);
      chk_push(v[0] ? VAL_ONE : VAL_ZERO);
      idle();
    end
  endtask
  task automatic t_threshold();
    logic [DATA_W-1:0] vals[4] = '{VAL_HALF - 32'h1, VAL_HALF,
                                   32'hFFFF_0000, VAL_ONE};
    logic exps[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++) begin
      drive(CIOFLX_OP_DRIVE_OUT_1, vals[k]);
      chk_bit(out1, exps[k], "out1 threshold");
      run(CIOFLX_OP_LOAD_OUT_1, 3'h0, VAL_A);
      chk_push(exps[k] ? VAL_ONE : VAL_ZERO);
      idle();
    end
    // Back to back: a load right after a store sees the stored value
    run(CIOFLX_OP_DRIVE_OUT_1, 3'h0, VAL_HALF - 32'h1);
    run(CIOFLX_OP_LOAD_OUT_1, 3'h0, VAL_A);
    chk_push(VAL_ZERO);
    run(CIOFLX_OP_STORE_FLAG, 3'h3, VAL_ONE);
    run(CIOFLX_OP_LOAD_FLAG, 3'h3, VAL_A);
    chk_push(VAL_ONE);
    idle();
  endtask
  task automatic t_opt_swap();
    do_reset(CIOFLX_VAR_OPT);
    run(CIOFLX_OP_LOAD_IN_1, 3'h0, VAL_A);
    chk_bit(err, 1'b1, "opt has no input load");
    chk_bit(we, 1'b0, "refused load writes");
    idle();
    drive(CIOFLX_OP_DRIVE_OUT_1, VAL_ZERO);
    chk_bit(out1, 1'b0, "opt out1");
    run(CIOFLX_OP_SWAP, 3'h0, VAL_A);
    chk_val(so.s1, stk.s2, "swap s1");
    chk_val(so.s2, VAL_A, "swap s2");
    chk_val({so.s3 ^ stk.s3} | {so.s4 ^ stk.s4}, '0, "swap s3 s4");
    idle();
    drive(CIOFLX_OP_DRIVE_OUT_2, VAL_ZERO);
    chk_bit(out2, 1'b0, "opt out2");
    chk_bit(closed[1], 1'b1, "relay 2 closed");
    run(CIOFLX_OP_LOAD_OUT_2, 3'h0, VAL_A);
    chk_push(VAL_ZERO);
    idle();
    drive(CIOFLX_OP_DRIVE_OUT_2, VAL_HALF);
    chk_bit(out2, 1'b1, "opt out2 released");
    chk_bit(closed[1], 1'b0, "relay 2 open");
  endtask
  task automatic t_flags();
    cioflx_variant_t vs[3] = '{CIOFLX_VAR_STD, CIOFLX_VAR_OPT, CIOFLX_VAR_NONE};
    for (int n = 0; n < 3; n++) begin
      do_reset(vs[n]);
      // Odd flags get 0, even 1, so two flags sharing a bit show up
      for (int i = 0; i < 6; i++) begin
        run(CIOFLX_OP_STORE_FLAG, 3'(i), i % 2 ? VAL_HALF - 32'h1 : VAL_HALF);
        chk_bit(err, !legal(vs[n], i), "flag store index");
        chk_keep();
        idle();
      end
      for (int i = 0; i < 6; i++) begin
        run(CIOFLX_OP_LOAD_FLAG, 3'(i), VAL_A);
        chk_bit(err, !legal(vs[n], i), "flag load index");
        if (legal(vs[n], i)) chk_push(i % 2 ? VAL_ZERO : VAL_ONE);
        idle();
      end
      chk_bit(out1, 1'b1, "flags leave pin 1");
      chk_bit(out2, 1'b1, "flags leave pin 2");
    end
  endtask
  task automatic t_terminate();
    run(CIOFLX_OP_TERMINATE, 3'h0, VAL_A);
    chk_bit(pend, 1'b1, "pass end pulse");
    chk_bit(we, 1'b0, "terminate keeps stack");
    idle();
    #2;
    chk_bit(pend, 1'b0, "pass end one cycle");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    resetn = 1'b0;
    variant = CIOFLX_VAR_STD;
    cmd = '{1'b0, CIOFLX_OP_NOP, 3'h0};
    stk = '{VAL_A, 32'h0003_2000, 32'h0004_3000, 32'h0005_4000};
    t_contact_in();
    t_threshold();
    t_terminate();
    t_opt_swap();
    t_flags();
    complete_run();
  end
endmodule
